// *** can_cfg_irq.sv ***
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module can_cfg_irq
	import can_cfg_pkg::*;
#(
	parameter int NB = NBUF
)(
	// ahb-lite slave
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// receive filter request from the protocol engine
	input  wire frame_hdr_t  rx_hdr,
	input  wire logic [28:0] buf_id,
	input  wire logic        buf_is_basic,
	// engine events, one-cycle pulses
	input  wire logic [NB-1:0] xfer_done,
	input  wire logic        bus_error,
	input  wire logic        node_state_chg,
	// filter answer and merged identifier
	output logic             rx_accept,
	output logic      [28:0] rx_merged_id,
	// bit time logic setup
	output bit_time_t        bit_time,
	// interrupt request
	output logic             irq
);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [15:0] timing_r,   timing_nxt;   // bit timing config
	logic [15:0] gmb_r,      gmb_nxt;      // global mask base
	logic [15:0] gmx_r,      gmx_nxt;      // global mask extended
	logic [15:0] bmb_r,      bmb_nxt;      // basic mask base
	logic [15:0] bmx_r,      bmx_nxt;      // basic mask extended
	logic [15:0] ien_r,      ien_nxt;      // interrupt enable
	logic [15:0] pend_r,     pend_nxt;     // interrupt pending
	logic        eit_r,      eit_nxt;      // error interrupt type
	// data-phase capture
	logic        wr_ph_r,    wr_ph_nxt;    // write in data phase
	logic [7:0]  addr_ph_r,  addr_ph_nxt;  // latched address
	logic [31:0] rdata_r,    rdata_nxt;    // read data
	// outputs held in flops
	logic        acc_r,      acc_nxt;
	logic [28:0] mid_r,      mid_nxt;
	bit_time_t   bt_r,       bt_nxt;
	logic        irq_r,      irq_nxt;

	logic        addr_ok;                  // valid address phase
	logic [31:0] gmask, bmask, mask, ref_cmp, care, diff;
	logic [28:0] keep_id;
	logic [15:0] set_v, clr_v;
	logic        err_evt;

	////////////////////////////////////////////////////////////////////////
	// bus decode; single-word only, always zero wait and okay
	always_comb begin
		addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);
	end

	// register read mux, unmapped reads give zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a,
		input logic [15:0] t, gb, gx, bb, bx, en, pd, input logic et);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			OFS_TIMING:   v = {16'h0000, t};
			OFS_GMASK_B:  v = {16'h0000, gb};
			OFS_GMASK_X:  v = {16'h0000, gx};
			OFS_BMASK_B:  v = {16'h0000, bb};
			OFS_BMASK_X:  v = {16'h0000, bx};
			OFS_IRQ_EN:   v = {16'h0000, en};
			OFS_IRQ_PEND: v = {16'h0000, pd};
			OFS_CONFIG:   v = {31'h0000_0000, et};
			default:      v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// acceptance filter
	// packs a mask pair into {id[28:0], srr/rtr, ide, ext_remote_mask} order
	function automatic logic [31:0] pack_mask(input logic [15:0] b,
		input logic [15:0] x);
		// hi bits, 17:15, the x word, then rtr, ide and x bit 0
		return {b[15:MSK_HI_LSB], b[2:0], x[15:1],
			b[MSK_RTR_BIT], b[MSK_IDE_BIT], x[0]};
	endfunction

	always_comb begin
		gmask = pack_mask(gmb_r, gmx_r);
		bmask = pack_mask(bmb_r, bmx_r);
		// basic mask for buffer 14 only
		mask  = buf_is_basic ? bmask : gmask;
		// unused bits forced to don't care for standard frames
		if (!rx_hdr.ide) begin
			mask[20:3] = 18'h3FFFF;
			mask[0]    = 1'b1;
		end
		// reference: buffer id, then the frame's own srr, ide and rtr bits
		ref_cmp = {buf_id, rx_hdr.srr, rx_hdr.ide, rx_hdr.rtr};
		care    = ~mask;
		diff    = ({rx_hdr.id, rx_hdr.srr, rx_hdr.ide, rx_hdr.rtr}
			^ ref_cmp) & care;
		// masked bits take the arrived value
		keep_id = (buf_id & care[31:3]) | (rx_hdr.id & mask[31:3]);
	end

	// filter registers its answer
	always_comb begin
		acc_nxt = (diff[31:3] == 29'h0000_0000);
		mid_nxt = keep_id;
	end

	////////////////////////////////////////////////////////////////////////
	// bit time decode
	always_comb begin
		logic [7:0] p;
		p = {1'b0, timing_r[15:PSC_LSB]} + PSC_OFFSET;
		// codes 126 and 127 both give 128
		bt_nxt.presc  = (p > PSC_MAX) ? PSC_MAX : p;
		bt_nxt.sjw_tq = {1'b0, timing_r[8:SJW_LSB]} + 3'h1;
		bt_nxt.ts1_tq = {1'b0, timing_r[6:TS1_LSB]} + 5'h01;
		bt_nxt.ts2_tq = {1'b0, timing_r[2:TS2_LSB]} + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// register file and pending flags
	always_comb begin
		timing_nxt  = timing_r;
		gmb_nxt     = gmb_r;
		gmx_nxt     = gmx_r;
		bmb_nxt     = bmb_r;
		bmx_nxt     = bmx_r;
		ien_nxt     = ien_r;
		eit_nxt     = eit_r;
		clr_v       = 16'h0000;
		wr_ph_nxt   = addr_ok && hwrite;
		addr_ph_nxt = addr_ok ? haddr : addr_ph_r;
		rdata_nxt   = (addr_ok && !hwrite) ? rd_mux(haddr, timing_r,
			gmb_r, gmx_r, bmb_r, bmx_r, ien_r, pend_r, eit_r) : rdata_r;
		// writes land in the data phase
		if (wr_ph_r) begin
			case (addr_ph_r)
				OFS_TIMING:  timing_nxt = hwdata[15:0];
				OFS_GMASK_B: gmb_nxt    = hwdata[15:0];
				OFS_GMASK_X: gmx_nxt    = hwdata[15:0];
				OFS_BMASK_B: bmb_nxt    = hwdata[15:0];
				OFS_BMASK_X: bmx_nxt    = hwdata[15:0];
				OFS_IRQ_EN:  ien_nxt    = hwdata[15:0];
				OFS_IRQ_CLR: clr_v      = hwdata[15:0];
				OFS_CONFIG:  eit_nxt    = hwdata[EIT_BIT];
				default: begin
					// unmapped and read-only writes ignored
				end
			endcase
		end
		// type bit picks the error source
		err_evt = eit_r ? node_state_chg : bus_error;
		set_v   = {err_evt, xfer_done};
		// set beats clear in the same cycle
		pend_nxt = (pend_r & ~clr_v) | set_v;
		// enable gates the request, not the flag
		irq_nxt  = |(pend_nxt & ien_nxt);
	end

	////////////////////////////////////////////////////////////////////////
	// all state flops, zero on reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing_r  <= RST_REG16;
			gmb_r     <= RST_REG16;
			gmx_r     <= RST_REG16;
			bmb_r     <= RST_REG16;
			bmx_r     <= RST_REG16;
			ien_r     <= RST_REG16;
			pend_r    <= RST_REG16;
			eit_r     <= 1'b0;
			wr_ph_r   <= 1'b0;
			addr_ph_r <= 8'h00;
			rdata_r   <= 32'h0000_0000;
			acc_r     <= 1'b0;
			mid_r     <= 29'h0000_0000;
			bt_r      <= '0;
			irq_r     <= 1'b0;
		end else begin
			timing_r  <= timing_nxt;
			gmb_r     <= gmb_nxt;
			gmx_r     <= gmx_nxt;
			bmb_r     <= bmb_nxt;
			bmx_r     <= bmx_nxt;
			ien_r     <= ien_nxt;
			pend_r    <= pend_nxt;
			eit_r     <= eit_nxt;
			wr_ph_r   <= wr_ph_nxt;
			addr_ph_r <= addr_ph_nxt;
			rdata_r   <= rdata_nxt;
			acc_r     <= acc_nxt;
			mid_r     <= mid_nxt;
			bt_r      <= bt_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// outputs straight from flops, hreadyout and hresp tied off; zero-wait slave
	always_comb begin
		hrdata       = rdata_r;
		hreadyout    = 1'b1;
		hresp        = 1'b0;
		rx_accept    = acc_r;
		rx_merged_id = mid_r;
		bit_time     = bt_r;
		irq          = irq_r;
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	property p_psc_sat;
		@(posedge hclk) disable iff (!hresetn)
		(timing_r[15:PSC_LSB] >= 7'h7E) |=> (bit_time.presc == 8'h80);
	endproperty
	a_psc_sat: assert property (p_psc_sat)
		else $error("prescale not saturated at 128");

	property p_sjw;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (bit_time.sjw_tq == {1'b0, $past(timing_r[8:7])} + 3'h1);
	endproperty
	a_sjw: assert property (p_sjw)
		else $error("jump width wrong");

	property p_ts2;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (bit_time.ts2_tq == {1'b0, $past(timing_r[2:0])} + 4'h1);
	endproperty
	a_ts2: assert property (p_ts2)
		else $error("second segment wrong");

	property p_ts1;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (bit_time.ts1_tq == {1'b0, $past(timing_r[6:3])} + 5'h01);
	endproperty
	a_ts1: assert property (p_ts1)
		else $error("first segment wrong");

	property p_exact_match;
		@(posedge hclk) disable iff (!hresetn)
		(mask == 32'h0000_0000 && rx_hdr.id != buf_id) |=> !rx_accept;
	endproperty
	a_exact_match: assert property (p_exact_match)
		else $error("accepted mismatching id with no mask");

	property p_merge;
		@(posedge hclk) disable iff (!hresetn)
		(mask[31:3] == 29'h1FFF_FFFF) |=> (rx_merged_id == $past(rx_hdr.id));
	endproperty
	a_merge: assert property (p_merge)
		else $error("masked bits not taken from frame");

	property p_buf_set;
		@(posedge hclk) disable iff (!hresetn)
		xfer_done[0] |=> pend_r[0];
	endproperty
	a_buf_set: assert property (p_buf_set)
		else $error("buffer pending not set");

	property p_err_clr;
		@(posedge hclk) disable iff (!hresetn)
		(wr_ph_r && addr_ph_r == OFS_IRQ_CLR && hwdata[ERR_BIT] && !err_evt)
		|=> !pend_r[ERR_BIT];
	endproperty
	a_err_clr: assert property (p_err_clr)
		else $error("error pending not cleared");

	property p_err_type;
		@(posedge hclk) disable iff (!hresetn)
		(eit_r && bus_error && !node_state_chg && !pend_r[ERR_BIT])
		|=> !pend_r[ERR_BIT];
	endproperty
	a_err_type: assert property (p_err_type)
		else $error("error pending set on wrong event");

	property p_irq;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> (irq == |(pend_r & ien_r));
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq does not follow pending and enable");

	// set wins over a clear landing in the same cycle
	property p_err_set;
		@(posedge hclk) disable iff (!hresetn)
		err_evt |=> pend_r[ERR_BIT];
	endproperty
	a_err_set: assert property (p_err_set)
		else $error("error pending not set on event");

	// pending word is read-only from the bus side
	property p_pend_ro;
		@(posedge hclk) disable iff (!hresetn)
		(wr_ph_r && addr_ph_r == OFS_IRQ_PEND
			&& xfer_done == '0 && !err_evt)
		|=> $stable(pend_r);
	endproperty
	a_pend_ro: assert property (p_pend_ro)
		else $error("pending changed by a bus write");

	// a zero basic mask means buffer 14 needs an exact id match
	property p_basic_exact;
		@(posedge hclk) disable iff (!hresetn)
		(buf_is_basic && rx_hdr.ide && bmb_r == 16'h0000
			&& bmx_r == 16'h0000 && rx_hdr.id != buf_id)
		|=> !rx_accept;
	endproperty
	a_basic_exact: assert property (p_basic_exact)
		else $error("basic buffer accepted a mismatching id");

	c_read: cover property (@(posedge hclk) disable iff (!hresetn)
		addr_ok && !hwrite && haddr == OFS_IRQ_PEND);
	c_accept: cover property (@(posedge hclk) disable iff (!hresetn)
		rx_accept && buf_is_basic);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(irq));
	c_err_clear: cover property (@(posedge hclk) disable iff (!hresetn)
		$fell(pend_r[ERR_BIT]));

endmodule

// *** can_cfg_pkg.sv ***
package can_cfg_pkg;

	// register word offsets (byte addresses)
	localparam logic [7:0] OFS_TIMING   = 8'h00;
	localparam logic [7:0] OFS_GMASK_B  = 8'h04;
	localparam logic [7:0] OFS_GMASK_X  = 8'h08;
	localparam logic [7:0] OFS_BMASK_B  = 8'h0C;
	localparam logic [7:0] OFS_BMASK_X  = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
	localparam logic [7:0] OFS_IRQ_PEND = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h1C;
	localparam logic [7:0] OFS_CONFIG   = 8'h20;

	// reset values
	localparam logic [15:0] RST_REG16 = 16'h0000;

	// timing register field positions
	localparam int PSC_LSB  = 9;
	localparam int SJW_LSB  = 7;
	localparam int TS1_LSB  = 3;
	localparam int TS2_LSB  = 0;

	// mask base word field positions
	localparam int MSK_HI_LSB  = 5;
	localparam int MSK_RTR_BIT = 4;
	localparam int MSK_IDE_BIT = 3;

	// interrupt word: error bit above the buffer bits
	localparam int ERR_BIT = 15;
	localparam int NBUF    = 15;
	localparam int BASIC_BUF = 14;

	// config register: error interrupt type bit
	localparam int EIT_BIT = 0;

	// prescale: field plus two, top code saturates
	localparam logic [7:0] PSC_OFFSET = 8'h02;
	localparam logic [7:0] PSC_MAX    = 8'h80;

	// received frame header as seen by the filter
	typedef struct packed {
		logic [28:0] id;   // standard id sits in id[28:18]
		logic        srr;  // srr for extended, rtr for standard
		logic        ide;
		logic        rtr;  // extended-frame rtr
	} frame_hdr_t;

	// bit time parameters in quanta
	typedef struct packed {
		logic [7:0] presc;
		logic [2:0] sjw_tq;
		logic [4:0] ts1_tq;
		logic [3:0] ts2_tq;
	} bit_time_t;

endpackage

// *** can_node_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// far-side stand-in: offers frames to the filter, raises engine events
module can_node_model
	import can_cfg_pkg::*;
(
	// clock
	input  wire logic            hclk,
	// frame against a candidate buffer
	output frame_hdr_t           rx_hdr,
	output logic      [28:0]     buf_id,
	output logic                 buf_is_basic,
	// one-cycle event pulses
	output logic      [NBUF-1:0] xfer_done,
	output logic                 bus_error,
	output logic                 node_state_chg
);
	// quiet at time zero
	initial begin
		rx_hdr = '0;
		buf_id = '0;
		buf_is_basic = 1'b0;
		xfer_done = '0;
		bus_error = 1'b0;
		node_state_chg = 1'b0;
	end
	// header held until the next offer, like a latched arbitration field
	task automatic offer(input frame_hdr_t h, input logic [28:0] b,
		input logic bas);
		@(posedge hclk);
		rx_hdr <= h;
		buf_id <= b;
		buf_is_basic <= bas;
	endtask
	// events last one cycle only; a longer pulse would hide edge bugs
	task automatic pulse(input logic [NBUF-1:0] d, input logic be,
		input logic ns);
		@(posedge hclk);
		xfer_done <= d;
		bus_error <= be;
		node_state_chg <= ns;
		@(posedge hclk);
		xfer_done <= '0;
		bus_error <= 1'b0;
		node_state_chg <= 1'b0;
	endtask
endmodule

// *** can_cfg_irq_bench.sv ***
`timescale 1ns/10ps
module can_cfg_irq_bench
	import can_cfg_pkg::*;
;
	// bus side
	logic            hclk = 1'b0;
	logic            hresetn = 1'b0;
	logic      [7:0] haddr = 8'h00;
	logic      [1:0] htrans = 2'h0;
	logic            hwrite = 1'b0;
	logic     [31:0] hwdata = 32'h0000_0000;
	logic     [31:0] hrdata;
	logic            hreadyout;
	logic            hresp;
	// filter, timing and interrupt side
	frame_hdr_t      rx_hdr;
	logic     [28:0] buf_id;
	logic     [28:0] rx_merged_id;
	logic            buf_is_basic;
	logic [NBUF-1:0] xfer_done;
	logic            bus_error;
	logic            node_state_chg;
	logic            rx_accept;
	logic            irq;
	bit_time_t       bit_time;
	// score
	int              err_count = 0;
	int              tests_run = 0;
	////////////////////////////////////////////////////////////////////////
	// 10 MHz clock
	always #50 hclk = ~hclk;
	// single slave: its ready is the bus ready
	can_cfg_irq i_can_cfg_irq (
		.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .rx_hdr, .buf_id, .buf_is_basic, .xfer_done,
		.bus_error, .node_state_chg, .rx_accept, .rx_merged_id,
		.bit_time, .irq
	);
	can_node_model i_can_node_model (
		.hclk, .rx_hdr, .buf_id, .buf_is_basic, .xfer_done,
		.bus_error, .node_state_chg
	);
	////////////////////////////////////////////////////////////////////////
	// verdict, reached from the main sequence or the watchdog
	task automatic give_verdict();
		if (err_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one word transfer; address held until ready, data until ready
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	// register read compare
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0000_0000, q);
		chk(q, e);
		// response is always okay
		chk(32'(hresp), 32'h0);
	endtask
	// let registered outputs land, then sample away from the edge
	task automatic settle();
		repeat (2) @(posedge hclk);
		@(negedge hclk);
	endtask
	// filter compare: accept flag, and merged id for extended hits
	task automatic filt(input frame_hdr_t h, input logic [28:0] b,
		input logic bas, input logic e);
		i_can_node_model.offer(h, b, bas);
		settle();
		chk(32'(rx_accept), 32'(e));
		if (e && h.ide) chk(32'(rx_merged_id), 32'(h.id));
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog: whole run is near four hundred cycles
	initial begin
		repeat (20000) @(posedge hclk);
		err_count++;
		give_verdict();
	end
	// main sequence
	initial begin
		logic [6:0] prescale_sel [4];
		logic [1:0] jump_width [4];
		logic [3:0] ts1 [4];
		logic [2:0] ts2 [4];
		logic [15:0] v;
		logic [7:0] p;
		logic [19:0] bt;
		frame_hdr_t ext;
		frame_hdr_t std;
		// jump width kept within both segments in every case
		prescale_sel = '{7'h00, 7'h01, 7'h7E, 7'h7F};
		jump_width = '{2'h0, 2'h1, 2'h3, 2'h2};
		ts1 = '{4'h1, 4'h5, 4'hF, 4'h3};
		ts2 = '{3'h0, 3'h3, 3'h7, 3'h2};
		ext = '{29'h0ABC_DEF5, 1'b1, 1'b1, 1'b0};
		std = '{29'h0ABC_DEF5, 1'b0, 1'b0, 1'b0};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// every register clear, unmapped word reads zero
		for (int a = 0; a <= 'h24; a += 4) rd_chk(8'(a), 0);
		// read/write words, upper half never stored
		for (int a = 'h04; a <= 'h14; a += 4) begin
			wr(8'(a), 32'hFFFF_A5C3);
			rd_chk(8'(a), 32'h0000_A5C3);
			wr(8'(a), 32'h0000_0000);
		end
		// prescale, jump width and segment codes, both top codes
		for (int i = 0; i < 4; i++) begin
			v = {prescale_sel[i], jump_width[i], ts1[i], ts2[i]};
			wr(OFS_TIMING, {16'h0000, v});
			rd_chk(OFS_TIMING, {16'h0000, v});
			p = (prescale_sel[i] == 7'h7F) ? 8'h80 : {1'b0, prescale_sel[i]} + 8'h02;
			settle();
			bt = {p, 3'(jump_width[i]) + 3'h1,
				5'(ts1[i]) + 5'h01, 4'(ts2[i]) + 4'h1};
			chk(32'(bit_time), 32'(bt));
		end
		// no mask at all: any id difference refuses
		filt(ext, ext.id ^ 29'h8000, 1'b0, 1'b0);
		// global mask: id bit 15 free
		wr(OFS_GMASK_B, 32'h0001);
		filt(ext, ext.id ^ 29'h8000, 1'b0, 1'b1);
		filt(ext, ext.id ^ 29'h4000, 1'b0, 1'b0);
		filt(std, std.id ^ 29'h1, 1'b0, 1'b1);
		filt(std, std.id ^ 29'h4_0000, 1'b0, 1'b0);
		wr(OFS_GMASK_X, 32'h8000);
		filt(ext, ext.id ^ 29'h4000, 1'b0, 1'b1);
		// buffer fourteen ignores the global mask
		filt(ext, ext.id ^ 29'h8000, 1'b1, 1'b0);
		wr(OFS_BMASK_B, 32'h0021);
		filt(ext, ext.id ^ 29'h8000, 1'b1, 1'b1);
		filt(std, std.id ^ 29'h4_0001, 1'b1, 1'b1);
		filt(std, std.id ^ 29'h4_0000, 1'b0, 1'b0);
		// every id bit free: whole id comes from the frame
		wr(OFS_GMASK_B, 32'hFFE7);
		wr(OFS_GMASK_X, 32'hFFFE);
		filt(ext, 29'h1555_5555, 1'b0, 1'b1);
		// buffer pending without enable, pending is read-only
		i_can_node_model.pulse(15'h0008, 1'b0, 1'b0);
		rd_chk(OFS_IRQ_PEND, 32'h0008);
		chk(32'(irq), 32'h0);
		wr(OFS_IRQ_PEND, 32'hFFFF);
		rd_chk(OFS_IRQ_PEND, 32'h0008);
		wr(OFS_IRQ_CLR, 32'h0008);
		wr(OFS_IRQ_EN, 32'h7FFF);
		// each buffer in turn raises its own bit and the request
		for (int i = 0; i < NBUF; i++) begin
			i_can_node_model.pulse(15'(1 << i), 1'b0, 1'b0);
			rd_chk(OFS_IRQ_PEND, 32'(1 << i));
			chk(32'(irq), 32'h1);
			wr(OFS_IRQ_CLR, 32'(1 << i));
			settle();
			chk(32'(irq), 32'h0);
		end
		// error on every bus error, request held off by enable
		wr(OFS_CONFIG, 32'h0000);
		i_can_node_model.pulse('0, 1'b1, 1'b0);
		rd_chk(OFS_IRQ_PEND, 32'h8000);
		chk(32'(irq), 32'h0);
		wr(OFS_IRQ_CLR, 32'h7FFF);
		rd_chk(OFS_IRQ_PEND, 32'h8000);
		wr(OFS_IRQ_EN, 32'h8000);
		settle();
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_CLR, 32'h8000);
		rd_chk(OFS_IRQ_PEND, 32'h0000);
		// error on node state change only
		wr(OFS_CONFIG, 32'h0001);
		i_can_node_model.pulse('0, 1'b1, 1'b0);
		rd_chk(OFS_IRQ_PEND, 32'h0000);
		i_can_node_model.pulse('0, 1'b0, 1'b1);
		rd_chk(OFS_IRQ_PEND, 32'h8000);
		chk(32'(irq), 32'h1);
		// mid-run reset clears written state and the request
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(OFS_IRQ_EN, 32'h0000);
		rd_chk(OFS_IRQ_PEND, 32'h0000);
		chk(32'(irq), 32'h0);
		give_verdict();
	end
endmodule
